// File: rtl/cuaf_sar.sv
`timescale 1ns/100ps
module cuaf_sar (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  cuaf_sar_if.conv sar
);
  cuaf_pkg::cuaf_sar_state_t state_q;
  logic [cuaf_pkg::SAMPLE_W-1:0] mask_q;
  logic [cuaf_pkg::SAMPLE_W-1:0] acc_q;
  logic [cuaf_pkg::SAMPLE_W-1:0] result_q;
  logic [3:0] settle_q;
  logic settled;
  logic [cuaf_pkg::SAMPLE_W-1:0] trial;
  logic [cuaf_pkg::SAMPLE_W-1:0] kept;

  assign trial = acc_q | mask_q;
  assign settled = (settle_q == 4'(cuaf_pkg::SAR_SETTLE_CYC - 1));
  // bit stays only when the input sits above the trial level
  assign kept = sar.comp ? trial : acc_q;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= cuaf_pkg::CUAF_SAR_IDLE;
      mask_q <= '0;
      acc_q <= '0;
      result_q <= cuaf_pkg::SAMPLE_RST;
      settle_q <= '0;
    end else begin
      unique case (state_q)
        cuaf_pkg::CUAF_SAR_IDLE: begin
          if (sar.start) begin
            state_q <= cuaf_pkg::CUAF_SAR_SETTLE;
            mask_q <= cuaf_pkg::MSB_MASK;
            acc_q <= '0;
            settle_q <= '0;
          end
        end
        cuaf_pkg::CUAF_SAR_SETTLE: begin
          settle_q <= settled ? 4'h0 : settle_q + 4'h1;
          if (settled) begin
            acc_q <= kept;
            mask_q <= mask_q >> 1;
            if (mask_q[0]) begin
              state_q <= cuaf_pkg::CUAF_SAR_DONE;
              result_q <= kept;
            end
          end
        end
        cuaf_pkg::CUAF_SAR_DONE: state_q <= cuaf_pkg::CUAF_SAR_IDLE;
        default: state_q <= cuaf_pkg::CUAF_SAR_IDLE;
      endcase
    end
  end

  assign sar.trial = trial;
  assign sar.result = result_q;
  assign sar.busy = (state_q == cuaf_pkg::CUAF_SAR_SETTLE);
  assign sar.done = (state_q == cuaf_pkg::CUAF_SAR_DONE);
endmodule // cuaf_sar

// File: rtl/cuaf_top.sv
`timescale 1ns/100ps
module cuaf_top #(
  parameter int DEB_CYC = cuaf_pkg::DEB_CYC,
  parameter int LCD_HALF_CYC = cuaf_pkg::LCD_HALF_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic mode_button_in,
  input wire logic shutter_button_in,
  input wire logic flash_ready_in,
  input wire logic flicker_select_in,
  input wire logic comparator_in,
  input wire logic led_on_in,
  input wire logic record_en_in,
  input wire logic play_en_in,
  input wire logic play_strobe_in,
  input wire logic [7:0] play_sample_in,
  input wire logic low_light_in,
  input wire logic continuous_req_in,
  input wire logic [6:0] digit0_in,
  input wire logic [6:0] digit1_in,
  output logic indicator_led_out,
  output logic amp_shutdown_out,
  output logic flash_trigger_n_out,
  output logic [7:0] dac_out,
  output logic [7:0] rec_sample_out,
  output logic rec_valid_out,
  output logic mode_level_out,
  output logic shutter_level_out,
  output logic flicker_60hz_out,
  output logic flash_mode_out,
  output logic continuous_mode_out,
  output logic capture_out,
  output logic [13:0] lcd_seg_out,
  output logic lcd_com_out
);
  localparam int SW = cuaf_pkg::SAMPLE_W;

  function automatic logic cnt_last(input logic [cuaf_pkg::CNT_W-1:0] c, input int n);
    cnt_last = (c == cuaf_pkg::CNT_W'(n - 1));
  endfunction

  function automatic logic [cuaf_pkg::CNT_W-1:0] cnt_inc(input logic [cuaf_pkg::CNT_W-1:0] c);
    cnt_inc = c + cuaf_pkg::CNT_W'(1);
  endfunction

  // ---------------- button debounce ----------------
  logic [1:0] btn_raw;
  logic [1:0] btn_q;
  logic [cuaf_pkg::CNT_W-1:0] deb_cnt_q [2];
  logic shutter_prev_q;
  logic shutter_press;

  assign btn_raw = {shutter_button_in, mode_button_in};

  // a level must hold unchanged for DEB_CYC cycles before it is accepted
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      btn_q <= 2'h0;
      deb_cnt_q[0] <= '0;
      deb_cnt_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (btn_raw[i] == btn_q[i]) begin
          deb_cnt_q[i] <= '0;
        end else if (cnt_last(deb_cnt_q[i], DEB_CYC)) begin
          btn_q[i] <= btn_raw[i];
          deb_cnt_q[i] <= '0;
        end else begin
          deb_cnt_q[i] <= cnt_inc(deb_cnt_q[i]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shutter_prev_q <= 1'b0;
    end else begin
      shutter_prev_q <= btn_q[1];
    end
  end

  assign shutter_press = btn_q[1] & ~shutter_prev_q;
  assign mode_level_out = btn_q[0];
  assign shutter_level_out = btn_q[1];

  // ---------------- strap and exposure mode ----------------
  logic strap_done_q;
  logic flicker_q;
  logic flash_q;
  logic cont_q;
  logic capture_q;
  logic led_q;
  logic take_pic;

  // strap is caught once after reset release; a board link does not move at run time
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_done_q <= 1'b0;
      flicker_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      flicker_q <= flicker_select_in;
    end
  end

  assign take_pic = shutter_press & (flash_q | ~low_light_in);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_q <= 1'b0;
      cont_q <= 1'b0;
      capture_q <= 1'b0;
      led_q <= 1'b0;
    end else begin
      flash_q <= flash_ready_in;
      cont_q <= continuous_req_in & ~flash_ready_in;
      capture_q <= take_pic;
      led_q <= led_on_in;
    end
  end

  assign flicker_60hz_out = flicker_q;
  assign flash_mode_out = flash_q;
  assign continuous_mode_out = cont_q;
  assign capture_out = capture_q;
  assign indicator_led_out = led_q;

  // ---------------- flash trigger ----------------
  cuaf_pkg::cuaf_fl_state_t fl_state_q;
  logic [cuaf_pkg::CNT_W-1:0] fl_cnt_q;
  logic fl_n_q;
  logic fl_wait_end;
  logic fl_fire_end;

  assign fl_wait_end = cnt_last(fl_cnt_q, cuaf_pkg::FLASH_DELAY_CYC);
  assign fl_fire_end = cnt_last(fl_cnt_q, cuaf_pkg::FLASH_PULSE_CYC);

  // the delay places the pulse where every sensor line integrates at once
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fl_state_q <= cuaf_pkg::CUAF_FL_IDLE;
      fl_cnt_q <= '0;
      fl_n_q <= 1'b1;
    end else begin
      unique case (fl_state_q)
        cuaf_pkg::CUAF_FL_IDLE: begin
          fl_cnt_q <= '0;
          if (capture_q && flash_q) begin
            fl_state_q <= cuaf_pkg::CUAF_FL_WAIT;
          end
        end
        cuaf_pkg::CUAF_FL_WAIT: begin
          fl_cnt_q <= fl_wait_end ? '0 : cnt_inc(fl_cnt_q);
          if (fl_wait_end) begin
            fl_state_q <= cuaf_pkg::CUAF_FL_FIRE;
            fl_n_q <= 1'b0;
          end
        end
        cuaf_pkg::CUAF_FL_FIRE: begin
          fl_cnt_q <= fl_fire_end ? '0 : cnt_inc(fl_cnt_q);
          if (fl_fire_end) begin
            fl_state_q <= cuaf_pkg::CUAF_FL_IDLE;
            fl_n_q <= 1'b1;
          end
        end
        default: fl_state_q <= cuaf_pkg::CUAF_FL_IDLE;
      endcase
    end
  end

  assign flash_trigger_n_out = fl_n_q;

  // ---------------- audio record and playback ----------------
  cuaf_sar_if sar ();
  logic [cuaf_pkg::CNT_W-1:0] smp_cnt_q;
  logic smp_tick;
  logic start_q;
  logic [SW-1:0] play_q;
  logic [SW-1:0] dac_q;
  logic [SW-1:0] rec_q;
  logic rec_valid_q;
  logic amp_off_q;

  cuaf_sar u_sar (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .sar(sar)
  );

  assign smp_tick = cnt_last(smp_cnt_q, cuaf_pkg::SAMPLE_CYC);
  assign sar.start = start_q;
  assign sar.comp = comparator_in;

  // fixed sample timer; the conversion fits well inside one period
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smp_cnt_q <= '0;
      start_q <= 1'b0;
    end else begin
      smp_cnt_q <= (smp_tick || !record_en_in) ? '0 : cnt_inc(smp_cnt_q);
      start_q <= smp_tick & record_en_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      play_q <= cuaf_pkg::SAMPLE_RST;
      dac_q <= cuaf_pkg::SAMPLE_RST;
      rec_q <= '0;
      rec_valid_q <= 1'b0;
      amp_off_q <= 1'b1;
    end else begin
      if (play_strobe_in) begin
        play_q <= play_sample_in;
      end
      dac_q <= record_en_in ? sar.trial : play_q;
      rec_valid_q <= sar.done;
      if (sar.done) begin
        rec_q <= sar.result;
      end
      // recording always wins so the search waveform never reaches the speaker
      amp_off_q <= record_en_in | sar.busy | ~play_en_in;
    end
  end

  assign dac_out = dac_q;
  assign rec_sample_out = rec_q;
  assign rec_valid_out = rec_valid_q;
  assign amp_shutdown_out = amp_off_q;

  // ---------------- static lcd drive ----------------
  logic [cuaf_pkg::CNT_W-1:0] lcd_cnt_q;
  logic lcd_flip;
  logic com_q;
  logic [13:0] seg_q;
  logic [13:0] lit;

  assign lcd_flip = cnt_last(lcd_cnt_q, LCD_HALF_CYC);
  assign lit = {digit1_in, digit0_in};

  // antiphase drive keeps the panel free of dc, which would age the fluid
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lcd_cnt_q <= '0;
      com_q <= 1'b0;
      seg_q <= '0;
    end else begin
      lcd_cnt_q <= lcd_flip ? '0 : cnt_inc(lcd_cnt_q);
      if (lcd_flip) begin
        com_q <= ~com_q;
      end
      seg_q <= lit ^ {14{com_q}};
    end
  end

  assign lcd_seg_out = seg_q;
  assign lcd_com_out = com_q;
endmodule // cuaf_top

// File: shared/cuaf_pkg.sv
// Function
// - Both the mode button and the shutter button are debounced inside the block before use.
// - The flicker select strap picks 50 Hz or 60 Hz anti-flicker timing as a board setting.
// - During recording the DAC output carries successive trial levels of a binary search.
// - After each trial level the comparator is sampled and decides the current bit.
// - Every recorded sample is resolved to an 8-bit value.
// - Samples are converted at a fixed 11 kHz rate with no faster rate available.
// - During playback the wanted sample level is driven on the DAC output.
// - The amplifier shutdown output holds the amplifier off throughout recording.
// - A high flash ready input switches exposure control to flash mode.
// - In flash mode there is no low-light rejection and a picture is always taken.
// - A shutter press in flash mode captures and pulses the flash trigger low within the capture.
// - Two seven-segment digits are driven directly, one output per segment, no multiplexing.
// - Display outputs are fourteen segment lines, 0 to 6 per digit as a to g, plus one common.
// - The display drive waveform is refreshed at 34.7 Hz.
// - Continuous capture mode cannot be selected while flash ready is high.
package cuaf_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;
  localparam int SAMPLE_HZ = 11_000;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  localparam int LCD_HZ_X10 = 347;
  localparam int LCD_HALF_CYC = (CLK_HZ / LCD_HZ_X10) * 10 / 2;
  localparam int DEB_MS = 20;
  localparam int DEB_CYC = (CLK_HZ / 1000) * DEB_MS;
  localparam int FLASH_DELAY_US = 100;
  localparam int FLASH_DELAY_CYC = FLASH_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int FLASH_PULSE_US = 50;
  localparam int FLASH_PULSE_CYC = FLASH_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int SAR_SETTLE_NS = 800;
  localparam int SAR_SETTLE_CYC = (SAR_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_W = 8;
  localparam int SEG_W = 7;
  localparam int CNT_W = 24;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 8'h80;
  localparam logic [SAMPLE_W-1:0] MSB_MASK = 8'h80;

  typedef enum logic [1:0] {
    CUAF_SAR_IDLE = 2'h0,
    CUAF_SAR_SETTLE = 2'h1,
    CUAF_SAR_DONE = 2'h3
  } cuaf_sar_state_t;

  typedef enum logic [1:0] {
    CUAF_FL_IDLE = 2'h0,
    CUAF_FL_WAIT = 2'h1,
    CUAF_FL_FIRE = 2'h3
  } cuaf_fl_state_t;
endpackage

// File: shared/cuaf_sar_if.sv
`timescale 1ns/100ps
interface cuaf_sar_if;
  logic start;
  logic comp;
  logic busy;
  logic done;
  logic [cuaf_pkg::SAMPLE_W-1:0] trial;
  logic [cuaf_pkg::SAMPLE_W-1:0] result;
  modport ctrl (output start, output comp, input busy, input done, input trial, input result);
  modport conv (input start, input comp, output busy, output done, output trial, output result);
endinterface

// File: test/cuaf_chk.sv
`timescale 1ns/100ps
module cuaf_chk #(
  parameter int DEB_CYC = 4,
  parameter int LCD_HALF_CYC = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic shutter_button_in,
  input wire logic flash_ready_in,
  input wire logic record_en_in,
  input wire logic [6:0] digit0_in,
  input wire logic [6:0] digit1_in,
  input wire logic amp_shutdown_out,
  input wire logic flash_trigger_n_out,
  input wire logic rec_valid_out,
  input wire logic shutter_level_out,
  input wire logic flash_mode_out,
  input wire logic continuous_mode_out,
  input wire logic capture_out,
  input wire logic [13:0] lcd_seg_out,
  input wire logic lcd_com_out
);
  int since_q, low_q, gap_q, run_q, hi_q;
  logic com_q, seen_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {since_q, low_q, gap_q, run_q, hi_q} <= '0;
      {com_q, seen_q} <= '0;
    end else begin
      since_q <= capture_out ? 1 : since_q + 1;
      low_q <= flash_trigger_n_out ? 0 : low_q + 1;
      // the first pulse after record starts has no full period behind it
      gap_q <= !record_en_in ? 0 : rec_valid_out ? 1 : gap_q + (gap_q != 0);
      com_q <= lcd_com_out;
      seen_q <= seen_q | (com_q != lcd_com_out);
      run_q <= (com_q != lcd_com_out) ? 1 : run_q + 1;
      hi_q <= shutter_button_in ? hi_q + 1 : 0;
    end
  end
  a_amp_rec_off: assert property (record_en_in |=> amp_shutdown_out)
    else $error("amplifier on while recording");
  a_cont_blocked: assert property (flash_ready_in |=> !continuous_mode_out)
    else $error("continuous mode with flash ready");
  a_flash_shot: assert property ($rose(shutter_level_out) && flash_mode_out |=> capture_out)
    else $error("flash mode press did not capture");
  a_trig_delay: assert property ($fell(flash_trigger_n_out) |->
    since_q == cuaf_pkg::FLASH_DELAY_CYC + 1)
    else $error("flash trigger at wrong time");
  a_trig_width: assert property ($rose(flash_trigger_n_out) |->
    low_q == cuaf_pkg::FLASH_PULSE_CYC)
    else $error("flash pulse width wrong");
  a_rec_rate: assert property (rec_valid_out && gap_q != 0 |->
    gap_q == cuaf_pkg::SAMPLE_CYC)
    else $error("sample spacing wrong");
  a_seg_phase: assert property ($past(rst_n_in) |-> lcd_seg_out ==
    ({$past(digit1_in), $past(digit0_in)} ^ {14{$past(lcd_com_out)}}))
    else $error("segment phase wrong");
  a_com_period: assert property (seen_q && com_q != lcd_com_out |->
    run_q == LCD_HALF_CYC)
    else $error("common period wrong");
  a_deb_hold: assert property ($rose(shutter_level_out) |-> hi_q >= DEB_CYC - 1)
    else $error("shutter accepted too early");
endmodule // cuaf_chk
bind cuaf_top cuaf_chk #(.DEB_CYC(DEB_CYC), .LCD_HALF_CYC(LCD_HALF_CYC)) i_chk (
  .sys_clk_in, .rst_n_in, .shutter_button_in, .flash_ready_in, .record_en_in,
  .digit0_in, .digit1_in, .amp_shutdown_out, .flash_trigger_n_out, .rec_valid_out,
  .shutter_level_out, .flash_mode_out, .continuous_mode_out, .capture_out,
  .lcd_seg_out, .lcd_com_out);

// File: test/cuaf_far.sv
`timescale 1ns/100ps
module cuaf_far (
  input wire logic [7:0] dac_in,
  input wire logic [7:0] level_in,
  output logic comp_out
);
  // half-step offset keeps the input off every trial level, so ties never occur
  assign comp_out = {level_in, 1'b1} > {dac_in, 1'b0};
endmodule // cuaf_far

// File: test/cuaf_top_tb_top.sv
`timescale 1ns/100ps
module cuaf_top_tb_top;
  logic clk = 0, rst_n = 0, mb = 0, sb = 0, fr = 0, fs = 0, led = 0, rec = 0;
  logic pen = 0, pst = 0, low = 0, creq = 0;
  logic [7:0] ps = 0, level = 0;
  logic [6:0] d0 = 0, d1 = 0;
  logic ledo, amp, trig, rv, ml, sl, f60, fm, cm, cap, com, comp;
  logic [7:0] dac, rs;
  logic [13:0] seg;
  int fails = 0, checked = 0;
  cuaf_top #(.DEB_CYC(4), .LCD_HALF_CYC(8)) i_dut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .mode_button_in(mb), .shutter_button_in(sb),
    .flash_ready_in(fr), .flicker_select_in(fs), .comparator_in(comp), .led_on_in(led),
    .record_en_in(rec), .play_en_in(pen), .play_strobe_in(pst), .play_sample_in(ps),
    .low_light_in(low), .continuous_req_in(creq), .digit0_in(d0), .digit1_in(d1),
    .indicator_led_out(ledo), .amp_shutdown_out(amp), .flash_trigger_n_out(trig),
    .dac_out(dac), .rec_sample_out(rs), .rec_valid_out(rv), .mode_level_out(ml),
    .shutter_level_out(sl), .flicker_60hz_out(f60), .flash_mode_out(fm),
    .continuous_mode_out(cm), .capture_out(cap), .lcd_seg_out(seg), .lcd_com_out(com));
  cuaf_far i_far (.dac_in(dac), .level_in(level), .comp_out(comp));
  always #50 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("Error t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    rst_n = 0;
    fs = s;
    tick(3);
    chk({trig, amp, dac}, {2'b11, 8'h80});
    chk({rs, rv, cap, seg, com}, 0);
    rst_n = 1;
    tick(2);
    fs = !s;
    tick(2);
    chk(f60, s);
  endtask
  task automatic press(output int at);
    at = 0;
    sb = 1;
    for (int k = 1; k <= 12; k++) begin
      tick(1);
      if (cap === 1'b1) at = k;
    end
    sb = 0;
    tick(12);
  endtask
  task automatic wait_rv(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (rv !== 1'b1 && n < 2000);
  endtask
  task automatic t_bounce();
    repeat (3) begin
      {mb, sb} = 2'b11;
      tick(2);
      {mb, sb} = 2'b00;
      tick(2);
    end
    chk({ml, sl}, 0);
    {mb, sb} = 2'b11;
    tick(8);
    chk({ml, sl}, 2'b11);
    {mb, sb} = 2'b00;
    tick(8);
    chk({ml, sl}, 0);
  endtask
  task automatic t_lcd();
    logic pc;
    int k;
    d0 = 7'h3f;
    d1 = 7'h06;
    led = 1;
    tick(2);
    pc = com;
    k = 0;
    repeat (32) begin
      tick(1);
      chk(seg, {d1, d0} ^ {14{pc}});
      k += (com !== pc);
      pc = com;
    end
    chk(k, 4);
    chk(ledo, 1);
  endtask
  task automatic t_rec();
    logic [7:0] lv [4] = '{8'h00, 8'hff, 8'ha5, 8'h5a};
    int n;
    rec = 1;
    pen = 1;
    foreach (lv[i]) begin
      level = lv[i];
      wait_rv(n);
      wait_rv(n);
      chk(n, cuaf_pkg::SAMPLE_CYC);
      tick(1);
      chk(rs, lv[i]);
      chk(amp, 1);
    end
    rec = 0;
    ps = 8'h3c;
    pst = 1;
    tick(1);
    pst = 0;
    tick(3);
    chk({dac, amp}, {8'h3c, 1'b0});
    pen = 0;
  endtask
  task automatic t_shots();
    int at, n;
    low = 1;
    press(at);
    chk(at, 0);
    fr = 1;
    creq = 1;
    tick(2);
    chk({fm, cm}, 2'b10);
    press(at);
    chk(at > 0, 1);
    n = 24 - at;
    while (trig !== 1'b0 && n < 2000) begin
      tick(1);
      n++;
    end
    chk(n, cuaf_pkg::FLASH_DELAY_CYC + 1);
    n = 0;
    while (trig !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    chk(n, cuaf_pkg::FLASH_PULSE_CYC);
    fr = 0;
    tick(2);
    chk({fm, cm}, 2'b01);
    low = 0;
    press(at);
    chk(at > 0, 1);
  endtask
  initial begin
    do_reset(1'b0);
    t_bounce();
    t_lcd();
    t_rec();
    t_shots();
    do_reset(1'b1);
    test_done();
  end
  initial begin
    #5000000;
    fails++;
    test_done();
  end
endmodule // cuaf_top_tb_top
